// File: ffd_pkg.sv
package ffd_pkg;
  // ****************************************************************
  // Register map and fields
  // ****************************************************************
  localparam logic [7:0] ADDR_DURATION = 8'hC0;
  localparam logic [7:0] ADDR_FLAGS = 8'hD0;
  localparam logic [7:0] DURATION_RESET = 8'hCF;
  localparam logic [7:0] FLAGS_RESET = 8'h40;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
  localparam int TIMEOUT_LSB = 0;
  localparam int TIMEOUT_MSB = 4;
  localparam int LIMIT_LSB = 5;
  localparam int LIMIT_MSB = 6;
  localparam int UNUSED_BIT = 7;
  localparam int FLAG_TIMEOUT = 0;
  localparam int FLAG_DIE_HOT = 1;
  localparam int FLAG_LED_FAIL = 2;
  localparam int FLAG_TX1 = 3;
  localparam int FLAG_TX2 = 4;
  localparam int FLAG_THERM = 5;
  localparam int FLAG_SPARE = 6;
  localparam int FLAG_VIN = 7;

  // ****************************************************************
  // Peak current limit codes and values
  // ****************************************************************
  localparam logic [1:0] LIMIT_1A0 = 2'h0;
  localparam logic [1:0] LIMIT_1A5 = 2'h1;
  localparam logic [1:0] LIMIT_2A0 = 2'h2;
  localparam logic [1:0] LIMIT_2A5 = 2'h3;
  localparam logic [11:0] PEAK_1A0_MA = 12'h3E8;
  localparam logic [11:0] PEAK_1A5_MA = 12'h5DC;
  localparam logic [11:0] PEAK_2A0_MA = 12'h7D0;
  localparam logic [11:0] PEAK_2A5_MA = 12'h9C4;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_HZ = 25000000;
  localparam int STEP_MS = 32;
  localparam int STEP_CYCLES = (CLK_HZ / 1000) * STEP_MS;
  localparam int STEP_CNT_W = 20;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // ****************************************************************
  // Serial slave states
  // ****************************************************************
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_PTR, ST_ACK_PTR,
    ST_WR, ST_ACK_WR, ST_RD, ST_ACK_RD
  } ffd_state_type;
endpackage

// File: ffd_timer_if.sv
`timescale 1ns/100ps
`default_nettype none
interface ffd_timer_if;
  logic run;
  logic [4:0] code;
  logic expired;
  logic expire_pulse;
  modport ctrl (output run, output code, input expired, input expire_pulse);
  modport timer (input run, input code, output expired, output expire_pulse);
endinterface
`default_nettype wire

// File: ffd_flash_timer.sv
`timescale 1ns/100ps
`default_nettype none
module ffd_flash_timer
  import ffd_pkg::*;
#(
  parameter int STEP_LEN = STEP_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  ffd_timer_if.timer tif
);
  logic [STEP_CNT_W-1:0] div;
  logic [5:0] steps;
  logic step_en;
  logic reach;

  // ****************************************************************
  // 32 ms step enable and expiry compare
  // ****************************************************************
  assign step_en = (div == STEP_CNT_W'(STEP_LEN - 1));
  assign reach = step_en && (steps == {1'b0, tif.code});

  // Counting restarts whenever the flash request drops
  always_ff @(posedge clk) begin
    if (sys_rst || !tif.run) begin
      div <= '0;
      steps <= '0;
      tif.expired <= 1'b0;
      tif.expire_pulse <= 1'b0;
    end else begin
      div <= step_en ? '0 : div + 1'b1;
      tif.expire_pulse <= reach && !tif.expired;
      if (reach) begin
        tif.expired <= 1'b1;
      end
      if (step_en && !tif.expired) begin
        steps <= steps + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// File: ffd_flash_regs.sv
`timescale 1ns/100ps
`default_nettype none
module ffd_flash_regs
  import ffd_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h2A, // Arbitrary value
  parameter int STEP_LEN = STEP_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic strobe_in,
  input wire logic led_fail_in,
  input wire logic die_hot_in,
  input wire logic thermistor_trip,
  input wire logic input_voltage_monitor,
  input wire logic tx1_in,
  input wire logic tx2_in,
  output logic flash_on,
  output logic [1:0] peak_limit_sel,
  output logic [11:0] peak_limit_ma,
  output logic [4:0] timeout_code
);
  import ffd_pkg::*;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [8:0] pin_meta;
  logic [8:0] pin_sync;
  logic [8:0] pin_prev;
  logic scl_s, sda_s, scl_d, sda_d;
  // Idle pin levels: bus lines and tx pins high, strobe and faults low
  localparam logic [8:0] PIN_IDLE = 9'h183;

  // Two stages; only the second stage feeds logic
  // Reset to idle levels, else a fake flag and flash pulse follow reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_meta <= PIN_IDLE;
      pin_sync <= PIN_IDLE;
      pin_prev <= PIN_IDLE;
    end else begin
      pin_meta <= {scl_in, sda_in, strobe_in, led_fail_in, die_hot_in,
                   thermistor_trip, input_voltage_monitor, tx1_in, tx2_in};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  assign scl_s = pin_sync[8];
  assign sda_s = pin_sync[7];
  assign scl_d = pin_prev[8];
  assign sda_d = pin_prev[7];

  // ****************************************************************
  // Bus condition decode
  // ****************************************************************
  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;
  assign bus_start = scl_s && scl_d && sda_d && !sda_s;
  assign bus_stop = scl_s && scl_d && !sda_d && sda_s;

  // ****************************************************************
  // Serial slave
  // ****************************************************************
  ffd_state_type state;
  logic [3:0] bit_cnt;
  logic [7:0] rx_shift;
  logic [7:0] tx_shift;
  logic [7:0] reg_ptr;
  logic is_read;
  logic got_nack;
  logic sda_low;
  logic wr_strobe;
  logic rd_done;
  logic byte_full;
  logic addr_hit;
  logic [7:0] rd_value;
  logic [7:0] duration;
  logic [7:0] flags;
  logic [7:0] rd_snap;

  assign byte_full = (bit_cnt == BYTE_BITS);
  assign addr_hit = (rx_shift[7:1] == DEV_ADDR);
  assign rd_value = (reg_ptr == ADDR_DURATION) ? duration :
                    (reg_ptr == ADDR_FLAGS) ? flags : READ_UNMAPPED;
  assign sda_out = 1'b0;
  assign sda_oe = sda_low;

  // Byte framing; ack and data change only while the clock is low
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      bit_cnt <= '0;
      rx_shift <= '0;
      tx_shift <= '0;
      reg_ptr <= '0;
      is_read <= 1'b0;
      got_nack <= 1'b0;
      sda_low <= 1'b0;
      wr_strobe <= 1'b0;
      rd_done <= 1'b0;
      rd_snap <= '0;
    end else begin
      wr_strobe <= 1'b0;
      rd_done <= 1'b0;
      if (bus_start) begin
        state <= ST_ADDR;
        bit_cnt <= '0;
        sda_low <= 1'b0;
      end else if (bus_stop) begin
        state <= ST_IDLE;
        sda_low <= 1'b0;
      end else if (scl_rise) begin
        case (state)
          ST_ADDR, ST_PTR, ST_WR: begin
            rx_shift <= {rx_shift[6:0], sda_s};
            bit_cnt <= bit_cnt + 1'b1;
          end
          ST_RD: bit_cnt <= bit_cnt + 1'b1;
          ST_ACK_RD: got_nack <= sda_s;
          default: ;
        endcase
      end else if (scl_fall) begin
        case (state)
          ST_ADDR: begin
            if (byte_full && addr_hit) begin
              state <= ST_ACK_ADDR;
              is_read <= rx_shift[0];
              sda_low <= 1'b1;
            end else if (byte_full) begin
              state <= ST_IDLE;
            end
          end
          ST_ACK_ADDR, ST_ACK_RD: begin
            bit_cnt <= '0;
            if (state == ST_ACK_RD && got_nack) begin
              state <= ST_IDLE;
              sda_low <= 1'b0;
            end else if (is_read) begin
              state <= ST_RD;
              tx_shift <= rd_value;
              rd_snap <= rd_value;
              sda_low <= !rd_value[7];
            end else begin
              state <= ST_PTR;
              sda_low <= 1'b0;
            end
          end
          ST_PTR, ST_WR: begin
            if (byte_full) begin
              state <= (state == ST_PTR) ? ST_ACK_PTR : ST_ACK_WR;
              sda_low <= 1'b1;
              if (state == ST_PTR) begin
                reg_ptr <= rx_shift;
              end else begin
                wr_strobe <= 1'b1;
              end
            end
          end
          ST_ACK_PTR, ST_ACK_WR: begin
            state <= ST_WR;
            bit_cnt <= '0;
            sda_low <= 1'b0;
          end
          ST_RD: begin
            if (byte_full) begin
              state <= ST_ACK_RD;
              sda_low <= 1'b0;
              rd_done <= 1'b1;
            end else begin
              sda_low <= !tx_shift[6];
              tx_shift <= {tx_shift[6:0], 1'b0};
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // ****************************************************************
  // Duration register and decode
  // ****************************************************************
  logic dur_wr;
  logic [11:0] next_peak_ma;
  assign dur_wr = wr_strobe && (reg_ptr == ADDR_DURATION);
  assign next_peak_ma = (duration[LIMIT_MSB:LIMIT_LSB] == LIMIT_1A0) ? PEAK_1A0_MA :
                        (duration[LIMIT_MSB:LIMIT_LSB] == LIMIT_1A5) ? PEAK_1A5_MA :
                        (duration[LIMIT_MSB:LIMIT_LSB] == LIMIT_2A0) ? PEAK_2A0_MA :
                        PEAK_2A5_MA;

  // Bit 7 is not writable so it always reads one
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      duration <= DURATION_RESET;
    end else if (dur_wr) begin
      duration <= {1'b1, rx_shift[LIMIT_MSB:TIMEOUT_LSB]};
    end
  end

  // Fields pulled out at their bit positions
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      peak_limit_sel <= DURATION_RESET[LIMIT_MSB:LIMIT_LSB];
      peak_limit_ma <= PEAK_2A0_MA;
      timeout_code <= DURATION_RESET[TIMEOUT_MSB:TIMEOUT_LSB];
    end else begin
      peak_limit_sel <= duration[LIMIT_MSB:LIMIT_LSB];
      peak_limit_ma <= next_peak_ma;
      timeout_code <= duration[TIMEOUT_MSB:TIMEOUT_LSB];
    end
  end

  // ****************************************************************
  // Flash timing
  // ****************************************************************
  ffd_timer_if tif ();
  assign tif.run = pin_sync[6];
  assign tif.code = duration[TIMEOUT_MSB:TIMEOUT_LSB];

  ffd_flash_timer #(
    .STEP_LEN(STEP_LEN)
  ) u_timer (
    .clk(clk),
    .sys_rst(sys_rst),
    .tif(tif)
  );

  // Flash stays off after expiry until the strobe is released
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flash_on <= 1'b0;
    end else begin
      flash_on <= tif.run && !tif.expired && !tif.expire_pulse;
    end
  end

  // ****************************************************************
  // Status flags
  // ****************************************************************
  logic [7:0] flag_set;
  logic [7:0] flag_clr;
  logic [7:0] next_flags;
  assign flag_set[FLAG_TIMEOUT] = tif.expire_pulse;
  assign flag_set[FLAG_DIE_HOT] = pin_sync[4];
  assign flag_set[FLAG_LED_FAIL] = pin_sync[5];
  assign flag_set[FLAG_TX1] = pin_sync[1] ^ pin_prev[1];
  assign flag_set[FLAG_TX2] = pin_sync[0] ^ pin_prev[0];
  assign flag_set[FLAG_THERM] = pin_sync[3];
  assign flag_set[FLAG_SPARE] = 1'b1;
  assign flag_set[FLAG_VIN] = pin_sync[2];
  // Clear only what the read showed, so a later event is not lost; a set wins
  assign flag_clr = (rd_done && reg_ptr == ADDR_FLAGS) ? (rd_snap & ~FLAGS_RESET) : 8'h00;
  assign next_flags = (flags & ~flag_clr) | flag_set;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flags <= FLAGS_RESET;
    end else begin
      flags <= next_flags;
    end
  end
endmodule
`default_nettype wire

// File: ffd_flash_regs_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module ffd_flash_regs_asserts
  import ffd_pkg::*;
#(
  parameter int STEP_LEN = STEP_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic scl_in,
  input wire logic strobe_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic flash_on,
  input wire logic [1:0] peak_limit_sel,
  input wire logic [11:0] peak_limit_ma,
  input wire logic [4:0] timeout_code
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ****************************************************************
  // Flash length counter
  // ****************************************************************
  // Counted here, since a repetition cannot hold the 25600000 cycles of a longest flash
  int on_cnt;
  always_ff @(posedge clk) begin
    on_cnt <= flash_on ? on_cnt + 1 : 0;
  end
  // ****************************************************************
  // Properties
  // ****************************************************************
  chk_limit_ma_map: assert property (
    peak_limit_ma == PEAK_1A0_MA + 12'h1F4 * peak_limit_sel) else $error("peak value bad");
  chk_reset_limit: assert property (
    disable iff (1'b0) sys_rst |=> peak_limit_sel == LIMIT_2A0)
    else $error("limit not 2A after reset");
  chk_reset_code: assert property (
    disable iff (1'b0) sys_rst |=> timeout_code == 5'h0F && !flash_on)
    else $error("reset outputs bad");
  chk_flash_bound: assert property (
    on_cnt <= (timeout_code + 1) * STEP_LEN) else $error("flash outlived timeout");
  chk_flash_cause: assert property (
    $rose(flash_on) |-> $past(strobe_in, 2)) else $error("flash without strobe");
  chk_strobe_low_off: assert property (
    !strobe_in [*5] |-> !flash_on) else $error("flash while strobe low");
  chk_sda_open_drain: assert property (
    sda_oe |-> !sda_out) else $error("sda driven high");
  chk_sda_scl_high: assert property (
    scl_in [*5] |-> $stable(sda_oe)) else $error("sda moved in scl high");
  chk_cfg_scl_high: assert property (
    scl_in [*5] |-> $stable(peak_limit_sel) && $stable(timeout_code))
    else $error("config moved in scl high");
  cover property ($fell(flash_on));
  cover property ($rose(sda_oe));
  cover property (peak_limit_sel == LIMIT_2A5);
endmodule
bind ffd_flash_regs ffd_flash_regs_asserts #(.STEP_LEN(STEP_LEN)) u_chk (.clk(clk),
  .sys_rst(sys_rst), .scl_in(scl_in), .strobe_in(strobe_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .flash_on(flash_on), .peak_limit_sel(peak_limit_sel),
  .peak_limit_ma(peak_limit_ma), .timeout_code(timeout_code));
`default_nettype wire

// File: tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  import ffd_pkg::*;
  localparam logic [6:0] DA = 7'h2A; // Arbitrary value
  logic clk = 0, sys_rst = 1, scl = 1, m_sda = 1, strobe = 0;
  logic [7:0] fv = 8'h18; // Fault levels by flag position, tx pins idle high
  logic sda_oe, sda_out, flash_on, a;
  logic [1:0] sel;
  logic [11:0] ma;
  logic [4:0] code;
  logic [7:0] d;
  int n_mismatch = 0, tests_run = 0, k;
  wire sda_w = m_sda & (sda_oe ? sda_out : 1'b1); // Open drain wire with pull-up
  always #20 clk = ~clk;
  ffd_flash_regs #(.DEV_ADDR(DA), .STEP_LEN(10)) DUT (.clk(clk), .sys_rst(sys_rst),
    .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .strobe_in(strobe),
    .led_fail_in(fv[2]), .die_hot_in(fv[1]), .thermistor_trip(fv[5]),
    .input_voltage_monitor(fv[7]), .tx1_in(fv[3]), .tx2_in(fv[4]), .flash_on(flash_on),
    .peak_limit_sel(sel), .peak_limit_ma(ma), .timeout_code(code));
  // ****************************************************************
  // Serial bus tasks
  // ****************************************************************
  task automatic tk(int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(logic [11:0] got, logic [11:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      n_mismatch++;
    end
  endtask
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Data only moves while scl is low, so no false start or stop
  task automatic bit_io(logic b, output logic r);
    m_sda <= b; tk(3); scl <= 1; tk(3); r = sda_w; tk(3); scl <= 0; tk(3);
  endtask
  task automatic start();
    m_sda <= 1; tk(3); scl <= 1; tk(6); m_sda <= 0; tk(6); scl <= 0; tk(3);
  endtask
  task automatic stop();
    m_sda <= 0; tk(3); scl <= 1; tk(6); m_sda <= 1; tk(6);
  endtask
  task automatic byte_io(logic [7:0] w, logic last, output logic [7:0] r, output logic ak);
    for (int i = 7; i >= 0; i--) bit_io(w[i], r[i]);
    bit_io(last, ak);
  endtask
  task automatic reg_wr(logic [7:0] p, logic [7:0] v);
    start(); byte_io({DA, 1'b0}, 1, d, a); byte_io(p, 1, d, a); byte_io(v, 1, d, a); stop();
  endtask
  task automatic reg_rd(logic [7:0] p, output logic [7:0] v);
    start(); byte_io({DA, 1'b0}, 1, d, a); byte_io(p, 1, d, a);
    start(); byte_io({DA, 1'b1}, 1, d, a); byte_io(8'hFF, 1, v, a); stop();
  endtask
  // ****************************************************************
  // Cases
  // ****************************************************************
  // Rows: written value, read back value, peak limit in mA
  logic [7:0] wv[4] = '{8'h00, 8'h3F, 8'h55, 8'h7E};
  logic [7:0] rv[4] = '{8'h80, 8'hBF, 8'hD5, 8'hFE};
  logic [11:0] mv[4] = '{PEAK_1A0_MA, PEAK_1A5_MA, PEAK_2A0_MA, PEAK_2A5_MA};
  int cw[2] = '{0, 31};
  int fb[6] = '{1, 2, 3, 4, 5, 7};
  initial begin
    begin : body
      tk(2); sys_rst <= 0; tk(6);
      chk(sel, LIMIT_2A0);
      reg_rd(ADDR_DURATION, d); chk(d, DURATION_RESET);
      reg_rd(ADDR_FLAGS, d); chk(d, FLAGS_RESET);
      for (int i = 0; i < 4; i++) begin
        reg_wr(ADDR_DURATION, wv[i]); reg_rd(ADDR_DURATION, d);
        chk(d, rv[i]); chk(sel, wv[i][6:5]); chk(ma, mv[i]);
        chk(code, wv[i][4:0]);
      end
      // Shortest and longest timeout codes, strobe held past the timeout
      foreach (cw[i]) begin
        reg_wr(ADDR_DURATION, 8'(cw[i]));
        strobe <= 1; k = 0;
        while (!flash_on && k < 20) begin tk(1); k++; end
        // A wait that runs out is a mismatch and goes straight to the report
        if (k >= 20) begin chk(flash_on, 1); disable body; end
        k = 0;
        while (flash_on && k < 400) begin tk(1); k++; end
        if (k >= 400) begin chk(flash_on, 0); disable body; end
        chk(12'(k), 12'((cw[i] + 1) * 10));
        tk(20); chk(flash_on, 0); strobe <= 0;
        reg_rd(ADDR_FLAGS, d); chk(d, 8'h41);
        reg_rd(ADDR_FLAGS, d); chk(d, FLAGS_RESET);
      end
      // Each fault raised or tx pin dropped briefly must stay latched until read
      foreach (fb[i]) begin
        fv[fb[i]] <= ~fv[fb[i]]; tk(6); fv[fb[i]] <= ~fv[fb[i]]; tk(6);
        reg_rd(ADDR_FLAGS, d); chk(d, FLAGS_RESET | (8'h01 << fb[i]));
      end
      reg_rd(8'hA0, d); chk(d, READ_UNMAPPED);
      start(); byte_io({DA ^ 7'h01, 1'b0}, 1, d, a); stop(); chk(a, 1);
      tk(1); sys_rst <= 1; tk(2); sys_rst <= 0; tk(6);
      reg_rd(ADDR_DURATION, d); chk(d, DURATION_RESET);
    end
    print_verdict();
  end
endmodule
`default_nettype wire
